// >>> core/crm_pkg.sv
package crm_pkg;
   // ****************************************
   // sizes
   // ****************************************
   localparam int unsigned CRM_WORDS     = 16;
   localparam int unsigned CRM_WIDTH     = 4;
   localparam int unsigned CRM_ADDR_W    = 4;
   localparam int unsigned CRM_SYNC_W    = 12;

   // ****************************************
   // reset values
   // ****************************************
   localparam logic [3:0]  CRM_WORD_RST  = 4'h0;
   localparam logic [3:0]  CRM_OUT_RST   = 4'hf;
   localparam logic [11:0] CRM_SYNC_RST  = 12'hb00;

   // ****************************************
   // field positions in the synchronised vector
   // ****************************************
   localparam int unsigned CRM_F_ADDR    = 0;
   localparam int unsigned CRM_F_DATA    = 4;
   localparam int unsigned CRM_F_WR_N    = 8;
   localparam int unsigned CRM_F_SEL_N   = 9;
   localparam int unsigned CRM_F_STROBE  = 10;
   localparam int unsigned CRM_F_OE_N    = 11;
endpackage

// >>> core/crm_clocked_ram.sv
`timescale 1ns/100ps
module crm_clocked_ram #(
   parameter int unsigned WORDS  = crm_pkg::CRM_WORDS,
   parameter int unsigned WIDTH  = crm_pkg::CRM_WIDTH,
   parameter int unsigned ADDR_W = crm_pkg::CRM_ADDR_W
)(
   input  wire logic              clk_in,
   input  wire logic              nrst_in,
   input  wire logic [ADDR_W-1:0] word_select_lines_in,
   input  wire logic [WIDTH-1:0]  write_value_lines_n_in,
   input  wire logic              write_strobe_n_in,
   input  wire logic              device_select_n_in,
   input  wire logic              edge_strobe_in,
   input  wire logic              output_drive_enable_n_in,
   output logic      [WIDTH-1:0]  read_lines_n_out,
   output logic                   read_lines_oe_out
);
   // ****************************************
   // pin synchronisers
   // ****************************************
   logic [crm_pkg::CRM_SYNC_W-1:0] pins_raw;
   logic [crm_pkg::CRM_SYNC_W-1:0] sync1_q;
   logic [crm_pkg::CRM_SYNC_W-1:0] sync2_q;
   logic [ADDR_W-1:0]              addr_s;
   logic [WIDTH-1:0]               data_s;
   logic                           wr_n_s;
   logic                           sel_n_s;
   logic                           strobe_s;
   logic                           oe_n_s;

   assign pins_raw = {output_drive_enable_n_in,
                      edge_strobe_in,
                      device_select_n_in,
                      write_strobe_n_in,
                      write_value_lines_n_in,
                      word_select_lines_in};

   // first stage, taken straight off the pins
   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         sync1_q <= crm_pkg::CRM_SYNC_RST;
      end
      else
      begin
         sync1_q <= pins_raw;
      end
   end

   // second stage, only reader of the first
   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         sync2_q <= crm_pkg::CRM_SYNC_RST;
      end
      else
      begin
         sync2_q <= sync1_q;
      end
   end

   // ****************************************
   // synchronised pin fields
   // ****************************************
   assign addr_s   = sync2_q[crm_pkg::CRM_F_ADDR +: ADDR_W];
   assign data_s   = sync2_q[crm_pkg::CRM_F_DATA +: WIDTH];
   assign wr_n_s   = sync2_q[crm_pkg::CRM_F_WR_N];
   assign sel_n_s  = sync2_q[crm_pkg::CRM_F_SEL_N];
   assign strobe_s = sync2_q[crm_pkg::CRM_F_STROBE];
   assign oe_n_s   = sync2_q[crm_pkg::CRM_F_OE_N];

   // ****************************************
   // helpers
   // ****************************************
   // one-hot word pick from an address
   function automatic logic [WORDS-1:0] word_pick(input logic [ADDR_W-1:0] addr);
      logic [WORDS-1:0] hot;
      hot = {WORDS{1'b0}};
      for (int unsigned k = 0; k < WORDS; k++)
      begin
         if (addr == ADDR_W'(k))
         begin
            hot[k] = 1'b1;
         end
      end
      return hot;
   endfunction

   // three active-low controls all asserted
   function automatic logic all_low(input logic a_n,
                                    input logic b_n,
                                    input logic c_n);
      return !a_n && !b_n && !c_n;
   endfunction

   // ****************************************
   // strobe edge and decode
   // ****************************************
   logic                           strobe_prev_q;
   logic                           strobe_rise;
   logic                           write_act;
   logic                           read_act;
   logic [WORDS-1:0]               word_hot;

   // strobe history, idles low like the pin
   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         strobe_prev_q <= 1'b0;
      end
      else
      begin
         strobe_prev_q <= strobe_s;
      end
   end

   assign write_act   = all_low(wr_n_s, sel_n_s, strobe_s);
   assign strobe_rise = strobe_s && !strobe_prev_q;
   assign read_act    = strobe_rise && !sel_n_s && wr_n_s;
   assign word_hot    = word_pick(addr_s);

   // ****************************************
   // write enables
   // ****************************************
   logic [WORDS-1:0]               write_hot;

   always_comb
   begin
      write_hot = {WORDS{1'b0}};
      if (write_act)
      begin
         write_hot = word_hot;
      end
   end

   // ****************************************
   // storage array
   // ****************************************
   logic [WIDTH-1:0]               mem_q [WORDS];

   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         for (int unsigned i = 0; i < WORDS; i++)
         begin
            mem_q[i] <= WIDTH'(crm_pkg::CRM_WORD_RST);
         end
      end
      else
      begin
         for (int unsigned i = 0; i < WORDS; i++)
         begin
            if (write_hot[i])
            begin
               mem_q[i] <= data_s;
            end
         end
      end
   end

   // ****************************************
   // read mux
   // ****************************************
   logic [WIDTH-1:0]               read_word;

   always_comb
   begin
      read_word = {WIDTH{1'b0}};
      for (int unsigned k = 0; k < WORDS; k++)
      begin
         if (word_hot[k])
         begin
            read_word = read_word | mem_q[k];
         end
      end
   end

   // ****************************************
   // output register
   // ****************************************
   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         read_lines_n_out <= WIDTH'(crm_pkg::CRM_OUT_RST);
      end
      else if (read_act)
      begin
         read_lines_n_out <= read_word;
      end
      else
      begin
         read_lines_n_out <= read_lines_n_out;
      end
   end

   // ****************************************
   // output drive enable
   // ****************************************
   always_ff @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         read_lines_oe_out <= 1'b0;
      end
      else
      begin
         read_lines_oe_out <= !oe_n_s;
      end
   end
endmodule

// >>> sim/crm_chk_sva.sv
`timescale 1ns/100ps
// ***
// output register checks
// ***
module crm_chk (
   input wire logic       clk_in,
   input wire logic       nrst_in,
   input wire logic [3:0] word_select_lines_in,
   input wire logic [3:0] write_value_lines_n_in,
   input wire logic       write_strobe_n_in,
   input wire logic       device_select_n_in,
   input wire logic       edge_strobe_in,
   input wire logic       output_drive_enable_n_in,
   input wire logic [3:0] read_lines_n_out,
   input wire logic       read_lines_oe_out
);
   logic       s_q;
   wire  [3:0] q  = read_lines_n_out;
   wire        rd = edge_strobe_in & ~s_q & ~device_select_n_in & write_strobe_n_in;
   always_ff @(posedge clk_in) s_q <= edge_strobe_in;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   a_oe_float: assert property ($past(output_drive_enable_n_in, 3) |-> !read_lines_oe_out) else $error("oe on");
   a_oe_drive: assert property (!$past(output_drive_enable_n_in, 3) |-> read_lines_oe_out) else $error("oe off");
   a_read_hold: assert property (rd |=> $stable(q)[*2]) else $error("early load");
   a_load_cause: assert property ($changed(q) |-> $past(rd, 3)) else $error("stray load");
   a_write_keep: assert property (!$past(write_strobe_n_in, 3) |-> $stable(q)) else $error("write moved out");
   a_sel_block: assert property ($past(device_select_n_in, 3) |-> $stable(q)) else $error("deselected load");
   a_strobe_low: assert property (!$past(edge_strobe_in, 3) |-> $stable(q)) else $error("low strobe load");
   a_strobe_high: assert property ($past(s_q, 3) |-> $stable(q)) else $error("held strobe load");
endmodule

bind crm_clocked_ram crm_chk u_crm_chk (.*);

// >>> sim/crm_ctl.sv
`timescale 1ns/100ps
// ***
// controlling logic model
// ***
module crm_ctl (
   input  wire logic       clk_in,
   output logic      [3:0] word_select_lines_in,
   output logic      [3:0] write_value_lines_n_in,
   output logic            write_strobe_n_in,
   output logic            device_select_n_in,
   output logic            edge_strobe_in,
   output logic            output_drive_enable_n_in
);
   initial {word_select_lines_in, write_value_lines_n_in, write_strobe_n_in,
            device_select_n_in, edge_strobe_in, output_drive_enable_n_in} = 12'h00d;
   // write, data moves mid write
   task automatic wr(input logic [3:0] a, input logic [3:0] d);
      @(negedge clk_in);
      {word_select_lines_in, write_value_lines_n_in} = {a, ~d};
      {write_strobe_n_in, device_select_n_in} = 2'h0;
      repeat (3) @(negedge clk_in);
      write_value_lines_n_in = d;
      repeat (3) @(negedge clk_in);
      {write_strobe_n_in, device_select_n_in} = 2'h3;
      repeat (2) @(negedge clk_in);
      write_value_lines_n_in = ~d;
   endtask
   // strobe rise, select given by s
   task automatic rd(input logic [3:0] a, input logic s);
      @(negedge clk_in);
      {word_select_lines_in, device_select_n_in} = {a, s};
      repeat (2) @(negedge clk_in);
      edge_strobe_in = 1'b1;
      repeat (3) @(negedge clk_in);
      {edge_strobe_in, device_select_n_in} = 2'h1;
      repeat (2) @(negedge clk_in);
   endtask
   // strobe rise during a write, d repeats the stored word
   task automatic rw(input logic [3:0] a, input logic [3:0] d);
      @(negedge clk_in);
      {word_select_lines_in, write_value_lines_n_in} = {a, d};
      {write_strobe_n_in, device_select_n_in} = 2'h0;
      repeat (2) @(negedge clk_in);
      edge_strobe_in = 1'b1;
      repeat (3) @(negedge clk_in);
      {edge_strobe_in, write_strobe_n_in, device_select_n_in} = 3'h3;
      repeat (2) @(negedge clk_in);
   endtask
   // output enable pin
   task automatic en(input logic v);
      @(negedge clk_in);
      output_drive_enable_n_in = v;
   endtask
endmodule

// >>> sim/tb_clocked_ram_16x4_regout.sv
`timescale 1ns/100ps
// ***
// bench
// ***
module tb_clocked_ram_16x4_regout;
   logic       clk_in = 1'b0;
   logic       nrst_in = 1'b0;
   logic [3:0] mem [16];
   int         bad_count = 0;
   int         tests_run = 0;
   wire  [3:0] word_select_lines_in, write_value_lines_n_in, read_lines_n_out;
   wire        write_strobe_n_in, device_select_n_in, edge_strobe_in;
   wire        output_drive_enable_n_in, read_lines_oe_out;
   crm_clocked_ram u_crm_clocked_ram (.*);
   crm_ctl         u_crm_ctl (.*);
   function automatic logic [3:0] want(input int a);
      return mem[a];
   endfunction
   task automatic chk(input logic [3:0] g, input logic [3:0] e);
      tests_run++;
      if (g !== e)
      begin
         bad_count++;
         $display("wrong value at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task automatic results;
      $display("tests_run %0d bad_count %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk_oe(input logic g, input logic e);
      tests_run++;
      if (g !== e)
      begin
         bad_count++;
         $display("wrong value at %0t: enable got %b want %b", $time, g, e);
      end
   endtask
   task automatic oe(input logic v);
      u_crm_ctl.en(v);
      repeat (4) @(negedge clk_in);
      chk_oe(read_lines_oe_out, ~v);
   endtask
   initial forever #5 clk_in = ~clk_in;
   initial
   begin
      void'($urandom(32'hb7fc7f3a));
      repeat (12) @(negedge clk_in);
      nrst_in = 1'b1;
      repeat (2) @(negedge clk_in);
      chk_oe(read_lines_oe_out, 1'b0);
      chk(read_lines_n_out, crm_pkg::CRM_OUT_RST);
      oe(1'b1);
      oe(1'b0);
      for (int i = 0; i < 16; i++)
      begin
         mem[i] = i == 0 ? 4'h0 : i == 15 ? 4'hf : 4'($urandom);
         u_crm_ctl.wr(4'(i), mem[i]);
      end
      for (int i = 15; i >= 0; i--)
      begin
         u_crm_ctl.rd(4'(i), 1'b0);
         chk(read_lines_n_out, want(i));
         u_crm_ctl.rd(4'(15 - i), 1'b1);
         u_crm_ctl.wr(4'(i), ~want(i));
         chk(read_lines_n_out, want(i));
         u_crm_ctl.rw(4'(i), ~want(i));
         chk(read_lines_n_out, want(i));
         mem[i] = ~mem[i];
      end
      for (int i = 0; i < 16; i++)
      begin
         u_crm_ctl.rd(4'(i), 1'b0);
         chk(read_lines_n_out, want(i));
      end
      oe(1'b1);
      results();
   end
endmodule
